// ==== core/srl_pkg.sv ====
// srl_pkg: shared constants for the serial register-access block
// assumes: both ends import it; the link interface does not
package srl_pkg;
	localparam int SRL_ADDR_W = 7;
	localparam int SRL_REGS = 128;
	localparam logic [6:0] SRL_ADDR_MEM0 = 7'h06;
	localparam logic [6:0] SRL_ADDR_MEM3 = 7'h09;
	localparam logic [6:0] SRL_ADDR_LOCK = 7'h0A;
	localparam logic [6:0] SRL_ADDR_SYSEN = 7'h04;
	localparam logic [6:0] SRL_ADDR_SYSEV = 7'h61;
	localparam logic [6:0] SRL_ADDR_ID = 7'h7E;
	localparam logic [6:0] SRL_ADDR_STAT = 7'h03;
	localparam logic [6:0] SRL_ADDR_MAX = 7'h7F;
	localparam int SRL_SYSEN_FAIL_BIT = 1;
	localparam int SRL_SYSEV_FAIL_BIT = 1;
	localparam logic [7:0] SRL_LOCK_MASK = 8'h7F;
	localparam logic [7:0] SRL_SYSEN_MASK = 8'h02;
	localparam logic [7:0] SRL_RESET_BYTE = 8'h00;
	localparam logic [7:0] SRL_RESET_SYSEN = 8'h02;
	localparam logic [7:0] SRL_ID_DEFAULT = 8'h5A;
	localparam int SRL_BITS_SHORT = 16;
	localparam int SRL_BITS_MID = 24;
	localparam int SRL_BITS_LONG = 32;
	localparam int SRL_CNT_W = 6;
	// host side register map
	localparam logic [11:0] SRL_H_CTRL = 12'h000;
	localparam logic [11:0] SRL_H_TXD = 12'h004;
	localparam logic [11:0] SRL_H_RXD = 12'h008;
	localparam logic [11:0] SRL_H_STAT = 12'h00C;
	localparam int SRL_H_DIV = 4;
	typedef enum logic [1:0] {
		SRL_H_IDLE = 2'b00,
		SRL_H_LOW = 2'b01,
		SRL_H_HIGH = 2'b10,
		SRL_H_END = 2'b11
	} srl_hstate_t;
endpackage : srl_pkg

// ==== core/srl_link_if.sv ====
// srl_link_if: four-wire serial link between controller and device
// assumes: serial_out is resolved here from its enable, low when not driven
`timescale 1ns/1ps
interface srl_link_if;
	logic sck;
	logic serial_select_n;
	logic serial_in;
	logic serial_out_o;
	logic serial_out_oe;
	logic serial_out;
	assign serial_out = serial_out_oe ? serial_out_o : 1'b0;
	modport device (input sck, input serial_select_n, input serial_in,
		output serial_out_o, output serial_out_oe);
	modport host (output sck, output serial_select_n, output serial_in,
		input serial_out);
endinterface : srl_link_if

// ==== core/srl_device.sv ====
// srl_device: serial slave with 128-byte register space, locks, scratch
// assumes: link pins asynchronous to CLOCK; sck well below CLOCK/4
`timescale 1ns/1ps
module srl_device
	import srl_pkg::*;
#(
	parameter logic [7:0] ID_CODE = SRL_ID_DEFAULT // arbitrary value
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	srl_link_if.device LINK,
	input wire logic MODE_CHANGE,
	input wire logic [7:0] STATUS_IN,
	output logic FAIL_EVENT,
	output logic [7:0] LOCK_STATE
);
	typedef struct packed {
		logic [2:0] sck_s;
		logic [2:0] sel_s;
		logic [1:0] din_s;
		logic [SRL_CNT_W-1:0] cnt;
		logic [7:0] shin;
		logic [7:0] shout;
		logic [6:0] addr;
		logic rd;
		logic abort;
		logic [2:0] nbytes;
		logic [7:0] wd0;
		logic [7:0] wd1;
		logic [7:0] wd2;
		logic [7:0] lock;
		logic [7:0] sysen;
		logic [7:0] sysev;
		logic [31:0] mem;
		logic dout;
		logic oe;
	} srl_dev_t;
	srl_dev_t s_reg, s_next;

	function automatic logic [7:0] rd_byte(input srl_dev_t s,
		input logic [6:0] a, input logic [7:0] st, input logic [7:0] id);
		logic [7:0] v;
		v = 8'h00;
		if (a >= SRL_ADDR_MEM0 && a <= SRL_ADDR_MEM3) begin
			v = s.mem[8*(a-SRL_ADDR_MEM0) +: 8];
		end else if (a == SRL_ADDR_LOCK) begin
			v = s.lock & SRL_LOCK_MASK;
		end else if (a == SRL_ADDR_SYSEN) begin
			v = s.sysen;
		end else if (a == SRL_ADDR_SYSEV) begin
			v = s.sysev;
		end else if (a == SRL_ADDR_ID) begin
			v = id;
		end else if (a == SRL_ADDR_STAT) begin
			v = st;
		end
		return v;
	endfunction : rd_byte

	function automatic logic locked(input logic [7:0] l, input logic [6:0] a);
		logic k;
		k = 1'b0;
		if (a >= SRL_ADDR_MEM0 && a <= SRL_ADDR_MEM3) begin
			k = l[0];
		end else if (a[6:4] == 3'h1) begin
			k = l[1];
		end else if (a[6:4] == 3'h2) begin
			k = l[2];
		end else if (a[6:4] == 3'h3) begin
			k = l[3];
		end else if (a[6:4] == 3'h4) begin
			k = l[4];
		end else if (a[6:4] == 3'h5) begin
			k = l[5];
		end else if (a[6:3] == 4'hD) begin
			k = l[6];
		end
		return k;
	endfunction : locked

	function automatic srl_dev_t wr_byte(input srl_dev_t s,
		input logic [6:0] a, input logic [7:0] d);
		srl_dev_t r;
		r = s;
		if (!locked(s.lock, a)) begin
			if (a >= SRL_ADDR_MEM0 && a <= SRL_ADDR_MEM3) begin
				r.mem[8*(a-SRL_ADDR_MEM0) +: 8] = d;
			end else if (a == SRL_ADDR_LOCK) begin
				r.lock = d & SRL_LOCK_MASK;
			end else if (a == SRL_ADDR_SYSEN) begin
				r.sysen = d & SRL_SYSEN_MASK;
			end else if (a == SRL_ADDR_SYSEV) begin
				r.sysev = s.sysev & ~d;
			end
		end
		return r;
	endfunction : wr_byte

	logic sck_rise, sck_fall, sel_fall, sel_rise, sel_act;
	logic [6:0] a1, a2;
	logic [7:0] fb;
	logic set_fail;
	assign sck_rise = s_reg.sck_s[1] && !s_reg.sck_s[2];
	assign sck_fall = !s_reg.sck_s[1] && s_reg.sck_s[2];
	assign sel_fall = !s_reg.sel_s[1] && s_reg.sel_s[2];
	assign sel_rise = s_reg.sel_s[1] && !s_reg.sel_s[2];
	assign sel_act = !s_reg.sel_s[1];

	always_comb begin
		s_next = s_reg;
		a1 = 7'h00;
		a2 = 7'h00;
		fb = 8'h00;
		set_fail = 1'b0;
		s_next.sck_s = {s_reg.sck_s[1:0], LINK.sck};
		s_next.sel_s = {s_reg.sel_s[1:0], LINK.serial_select_n};
		s_next.din_s = {s_reg.din_s[0], LINK.serial_in};
		s_next.oe = sel_act;
		if (sel_fall) begin
			s_next.cnt = '0;
			s_next.abort = 1'b0;
			s_next.nbytes = 3'd0;
			s_next.rd = 1'b0;
			// bits left from a cut frame must not leak into this one
			s_next.shout = 8'h00;
			s_next.dout = 1'b0;
		end else if (sel_act && sck_fall) begin
			fb = {s_reg.shin[6:0], s_reg.din_s[1]};
			s_next.shin = fb;
			if (s_reg.cnt != '1) begin
				s_next.cnt = s_reg.cnt + 1'b1;
			end
			if (s_reg.cnt[2:0] == 3'd7 && s_reg.cnt < 6'd32) begin
				if (s_reg.cnt[5:3] == 3'd0) begin
					s_next.addr = fb[7:1];
					s_next.rd = fb[0];
				end else begin
					s_next.nbytes = s_reg.nbytes + 3'd1;
				end
				if (s_reg.cnt[5:3] == 3'd1) begin
					s_next.wd0 = fb;
				end
				if (s_reg.cnt[5:3] == 3'd2) begin
					s_next.wd1 = fb;
				end
				if (s_reg.cnt[5:3] == 3'd3) begin
					s_next.wd2 = fb;
				end
			end
		end else if (sel_act && sck_rise) begin
			if (s_reg.cnt >= 6'd32 && s_reg.rd) begin
				s_next.dout = s_reg.din_s[1];
			end else if (s_reg.cnt[2:0] == 3'd0 && s_reg.cnt != 6'd0) begin
				// load byte at addr plus the data bytes already sent
				s_next.shout = rd_byte(s_reg,
					s_reg.addr + 7'(s_reg.nbytes), STATUS_IN, ID_CODE);
				s_next.dout = s_next.shout[7];
			end else begin
				s_next.dout = s_reg.shout[7];
			end
			s_next.shout = {s_next.shout[6:0], 1'b0};
			if (s_reg.cnt[2:0] == 3'd0 && s_reg.cnt != 6'd0 &&
				!(s_reg.cnt >= 6'd32 && s_reg.rd)) begin
				s_next.shout = {s_next.shout[7:1], 1'b0};
			end
		end
		if (sel_act && s_reg.cnt == 6'd0 && !s_reg.sck_s[1]) begin
			s_next.dout = 1'b0;
		end
		if (MODE_CHANGE && sel_act) begin
			s_next.abort = 1'b1;
		end
		if (sel_rise && !s_reg.rd && !s_reg.abort) begin
			if (s_reg.cnt == 6'(SRL_BITS_SHORT) || s_reg.cnt ==
				6'(SRL_BITS_MID) || s_reg.cnt == 6'(SRL_BITS_LONG)) begin
				a1 = s_reg.addr + 7'd1;
				a2 = s_reg.addr + 7'd2;
				s_next = wr_byte(s_next, s_reg.addr, s_reg.wd0);
				if (s_reg.cnt >= 6'(SRL_BITS_MID) &&
					s_reg.addr != SRL_ADDR_MAX) begin
					s_next = wr_byte(s_next, a1, s_reg.wd1);
				end
				if (s_reg.cnt == 6'(SRL_BITS_LONG) &&
					s_reg.addr < 7'h7E) begin
					s_next = wr_byte(s_next, a2, s_reg.wd2);
				end
			end else begin
				set_fail = s_reg.sysen[SRL_SYSEN_FAIL_BIT];
			end
		end
		if (set_fail) begin
			s_next.sysev[SRL_SYSEV_FAIL_BIT] = 1'b1; // set beats clear
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			s_reg <= '0;
			s_reg.sck_s <= 3'b000;
			s_reg.sel_s <= 3'b111;
			s_reg.sysen <= SRL_RESET_SYSEN;
			s_reg.lock <= SRL_RESET_BYTE;
		end else begin
			s_reg <= s_next;
		end
	end

	// first-byte output during a frame is zero, since shout is cleared at select fall
	assign LINK.serial_out_o = s_reg.dout;
	assign LINK.serial_out_oe = s_reg.oe;
	assign FAIL_EVENT = s_reg.sysev[SRL_SYSEV_FAIL_BIT];
	assign LOCK_STATE = s_reg.lock;
endmodule : srl_device

// ==== core/srl_host.sv ====
// srl_host: APB-controlled serial master issuing one frame per command
// assumes: device samples on falling sck; sck idles low
`timescale 1ns/1ps
module srl_host
	import srl_pkg::*;
#(
	parameter int DIV = SRL_H_DIV
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	srl_link_if.host LINK,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	typedef struct packed {
		srl_hstate_t st;
		logic [7:0] div;
		logic [5:0] nbits;
		logic [5:0] left;
		logic [31:0] tx;
		logic [31:0] rx;
		logic [1:0] din_s;
		logic sck;
		logic csn;
		logic mosi;
		logic [31:0] prdata;
	} srl_host_s_t;
	srl_host_s_t s_reg, s_next;
	logic acc, busy;
	assign acc = PSEL && PENABLE;
	assign busy = s_reg.st != SRL_H_IDLE;

	always_comb begin
		s_next = s_reg;
		s_next.din_s = {s_reg.din_s[0], LINK.serial_out};
		// loaded in setup so read data stands at the access edge
		if (PSEL && !PENABLE && !PWRITE) begin
			if (PADDR == SRL_H_RXD) begin
				s_next.prdata = s_reg.rx;
			end else if (PADDR == SRL_H_TXD) begin
				s_next.prdata = s_reg.tx;
			end else if (PADDR == SRL_H_STAT) begin
				s_next.prdata = {31'h0, busy};
			end else begin
				s_next.prdata = 32'h0;
			end
		end
		if (acc && PWRITE && !busy) begin
			if (PADDR == SRL_H_TXD) begin
				s_next.tx = PWDATA;
			end else if (PADDR == SRL_H_CTRL && PWDATA[5:0] != 6'd0) begin
				s_next.nbits = PWDATA[5:0];
				s_next.left = PWDATA[5:0];
				s_next.st = SRL_H_LOW;
				s_next.csn = 1'b0;
				s_next.div = 8'd0;
				s_next.mosi = s_reg.tx[31];
			end
		end
		if (busy) begin
			s_next.div = s_reg.div + 8'd1;
			if (s_reg.div == 8'(DIV - 1)) begin
				s_next.div = 8'd0;
				case (s_reg.st)
					SRL_H_LOW: begin
						s_next.sck = 1'b1;
						s_next.mosi = s_reg.tx[31];
						s_next.tx = {s_reg.tx[30:0], 1'b0};
						// reply taken half a period late: the device
						// answers through two synchronisers
						if (s_reg.left != s_reg.nbits) begin
							s_next.rx = {s_reg.rx[30:0], s_reg.din_s[1]};
						end
						s_next.st = SRL_H_HIGH;
					end
					SRL_H_HIGH: begin
						s_next.sck = 1'b0;
						s_next.left = s_reg.left - 6'd1;
						s_next.st = (s_reg.left == 6'd1) ? SRL_H_END : SRL_H_LOW;
					end
					SRL_H_END: begin
						s_next.rx = {s_reg.rx[30:0], s_reg.din_s[1]};
						s_next.csn = 1'b1;
						s_next.st = SRL_H_IDLE;
					end
					default: begin
						s_next.st = SRL_H_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			s_reg <= '0;
			s_reg.csn <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign LINK.sck = s_reg.sck;
	assign LINK.serial_select_n = s_reg.csn;
	assign LINK.serial_in = s_reg.mosi;
	assign PRDATA = s_reg.prdata;
	assign PREADY = PSEL && PENABLE;
	assign PSLVERR = 1'b0;
endmodule : srl_host

// ==== verification/srl_link_sva.sv ====
// srl_link_sva: timing checks on the serial link between host and device
// assumes: host built with its default clock divider of four
`timescale 1ns/1ps
module srl_link_sva (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic sck,
	input wire logic serial_select_n,
	input wire logic serial_in,
	input wire logic serial_out_oe
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESETN);
	// device sees select through a synchroniser, hence the slack
	sequence oe_drop;
		##[1:6] !serial_out_oe;
	endsequence
	sequence frame_hold;
		!sck ##0 !serial_select_n[*8];
	endsequence
	oe_idle_a:
		assert property (serial_select_n[*6] |-> !serial_out_oe)
		else $error("output driven while deselected");
	oe_drop_a:
		assert property ($rose(serial_select_n) |-> oe_drop)
		else $error("output not released after frame");
	oe_sel_a:
		assert property ($rose(serial_out_oe) |-> !serial_select_n)
		else $error("output enabled outside a frame");
	sck_idle_a:
		assert property (serial_select_n |-> !sck)
		else $error("clock not idle low between frames");
	frame_open_a:
		assert property ($fell(serial_select_n) |-> frame_hold)
		else $error("frame opened with clock high or cut short");
	sck_high_a:
		assert property ($rose(sck) |-> sck[*4] ##1 !sck)
		else $error("clock high phase not four cycles");
	sck_low_a:
		assert property ($fell(sck) |-> !sck[*4])
		else $error("clock low phase shorter than four cycles");
	din_stable_a:
		assert property (sck && $past(sck) |-> $stable(serial_in))
		else $error("input data moved while clock high");
endmodule : srl_link_sva

// ==== verification/tb.sv ====
// tb: host and device joined over the link, driven through APB
// assumes: default divider and identity code, APB answers at once
`timescale 1ns/1ps
module tb;
	import srl_pkg::*;
	logic clock = 1'h0;
	logic reset_n = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic mode_change = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] status_in = 8'h00;
	logic [31:0] prdata, got, want, d, s;
	logic pready, pslverr, fail_event;
	logic [7:0] lock_state;
	logic [31:0] exp_q[$];
	int errors = 0;
	int comparisons = 0;
	event got_ev;
	always #5 clock = ~clock;
	srl_link_if link();
	srl_host srl_host_inst(.CLOCK(clock), .RESETN(reset_n), .LINK(link),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	srl_device srl_device_inst(.CLOCK(clock), .RESETN(reset_n), .LINK(link),
		.MODE_CHANGE(mode_change), .STATUS_IN(status_in),
		.FAIL_EVENT(fail_event), .LOCK_STATE(lock_state));
	srl_link_sva srl_link_sva_inst(.CLOCK(clock), .RESETN(reset_n),
		.sck(link.sck), .serial_select_n(link.serial_select_n),
		.serial_in(link.serial_in), .serial_out_oe(link.serial_out_oe));
	task automatic finish_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'h1;
		do begin
			@(posedge clock);
		end while (pready !== 1'h1);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// one frame: load shift data, start, poll busy, fetch what came back
	task automatic frame(input logic [5:0] n, input logic [31:0] tx);
		int k;
		apb(1'h1, SRL_H_TXD, tx, s);
		apb(1'h1, SRL_H_CTRL, {26'h0, n}, s);
		k = 0;
		do begin
			apb(1'h0, SRL_H_STAT, 32'h0, s);
			k++;
		end while (s[0] !== 1'h0 && k < 200);
		if (k >= 200) errors++;
		apb(1'h0, SRL_H_RXD, 32'h0, s);
	endtask : frame
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		exp_q.push_back(e);
		got = g;
		-> got_ev;
		@(negedge clock);
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [5:0] n,
		input logic [23:0] dd);
		frame(n, {a, 1'h0, dd});
	endtask : wr
	// read frames carry random input bits, which must be ignored
	task automatic rd(input logic [6:0] a, input logic [5:0] n,
		input logic [31:0] e);
		logic [31:0] m;
		m = 32'((64'h1 << n) - 64'h1);
		frame(n, {a, 1'h1, 24'($urandom)});
		chk(s & m, e);
	endtask : rd
	initial forever begin
		@(got_ev);
		want = exp_q.pop_front();
		comparisons++;
		if (got !== want) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	end
	initial begin
		repeat (60000) @(posedge clock);
		errors++;
		finish_test;
	end
	initial begin
		void'($urandom(72683));
		d = $urandom;
		repeat (5) @(posedge clock);
		reset_n <= 1'h1;
		status_in <= d[31:24];
		wr(SRL_ADDR_MEM0, 6'h10, {d[7:0], 16'h0});
		rd(SRL_ADDR_MEM0, 6'h10, {24'h0, d[7:0]});
		wr(SRL_ADDR_MEM0 + 7'h01, 6'h20, d[23:0]);
		rd(SRL_ADDR_MEM0, 6'h20, {8'h0, d[7:0], d[23:8]});
		$display("test scratch done");
		wr(SRL_ADDR_MEM3, 6'h14, ~d[23:0]);
		chk({31'h0, fail_event}, 32'h1);
		rd(SRL_ADDR_MEM3, 6'h18, {16'h0, d[7:0], 8'h0});
		wr(SRL_ADDR_SYSEV, 6'h10, {8'h02, 16'h0});
		chk({31'h0, fail_event}, 32'h0);
		wr(SRL_ADDR_SYSEN, 6'h10, 24'h0);
		wr(SRL_ADDR_MEM3, 6'h08, 24'h0);
		chk({31'h0, fail_event}, 32'h0);
		wr(SRL_ADDR_SYSEN, 6'h10, {SRL_RESET_SYSEN, 16'h0});
		wr(SRL_ADDR_MAX, 6'h18, 24'hFFFF00);
		chk({31'h0, fail_event}, 32'h0);
		rd(SRL_ADDR_ID, 6'h10, {24'h0, SRL_ID_DEFAULT});
		$display("test length done");
		wr(SRL_ADDR_LOCK, 6'h10, {8'hFF, 16'h0});
		chk({24'h0, lock_state}, 32'h7F);
		rd(SRL_ADDR_LOCK, 6'h10, 32'h7F);
		wr(SRL_ADDR_MEM0, 6'h10, {~d[7:0], 16'h0});
		rd(SRL_ADDR_MEM0, 6'h10, {24'h0, d[7:0]});
		rd(SRL_ADDR_STAT, 6'h10, {24'h0, d[31:24]});
		wr(SRL_ADDR_LOCK, 6'h10, 24'h0);
		$display("test lock done");
		// a mode change mid-frame must throw the write away
		fork
			wr(SRL_ADDR_MEM0, 6'h10, {~d[7:0], 16'h0});
			begin
				repeat (80) @(posedge clock);
				mode_change <= 1'h1;
				@(posedge clock);
				mode_change <= 1'h0;
			end
		join
		rd(SRL_ADDR_MEM0, 6'h10, {24'h0, d[7:0]});
		$display("test mode done");
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			wr(SRL_ADDR_MEM0 + 7'(i), 6'h10, {d[7:0], 16'h0});
			rd(SRL_ADDR_MEM0 + 7'(i), 6'h10, {24'h0, d[7:0]});
		end
		$display("test random done");
		@(posedge clock);
		finish_test;
	end
endmodule : tb
